// File: rtl/spi_cmd_params.svh
// Frame positions, lengths and reset values of the serial command port
`ifndef SPI_CMD_PARAMS_SVH
`define SPI_CMD_PARAMS_SVH
`define FRAME_RW_LEN    7'd72
`define FRAME_ST_LEN    7'd40
`define POS_OPC_HI      7'd2
`define POS_ADDR_LAST   7'd32
`define POS_DATA_LAST   7'd64
`define POS_RD_STATUS   7'd40
`define POS_ST_STATUS   7'd8
`define SYNC_RESET      6'h24
`define DONE_RESET      1'b1
`define LAST_BE_RESET   4'hf
`define LAST_ADDR_RESET 24'h000000
`endif

// File: rtl/spi_cmd_pkg.sv
// Types shared by the serial command port and its access engine
package spi_cmd_pkg;
  typedef enum logic [1:0] {
    OP_STATUS = 2'h0,
    OP_WRITE  = 2'h1,
    OP_READ   = 2'h2,
    OP_NOP    = 2'h3
  } opcode_t;
  typedef enum logic [1:0] {
    ENG_IDLE = 2'h1,
    ENG_BUSY = 2'h2
  } eng_state_t;
endpackage

// File: rtl/access_if.sv
// Carrier between frame logic and access engine
interface access_if;
  import spi_cmd_pkg::*;
  logic        start;
  opcode_t     op;
  logic [3:0]  beN;
  logic [23:0] addr;
  logic [31:0] wdata;
  logic        done;
  opcode_t     lastOp;
  logic [3:0]  lastBeN;
  logic [23:0] lastAddr;
  logic [31:0] rdata;
  modport frame (output start, op, beN, addr, wdata,
                 input done, lastOp, lastBeN, lastAddr, rdata);
  modport engine (input start, op, beN, addr, wdata,
                  output done, lastOp, lastBeN, lastAddr, rdata);
endinterface

// File: rtl/access_engine.sv
// Internal 32-bit access engine with previous-access record
`include "spi_cmd_params.svh"
module access_engine
  import spi_cmd_pkg::*;
(
  input  wire logic        mclk,      // System clock
  input  wire logic        reset,     // Synchronous reset
  access_if.engine         acc,       // From frame logic
  output logic             accReq,    // Access request level
  output logic             accWrite,  // Access is a write
  output logic [23:0]      accAddr,   // Word address
  output logic [3:0]       accBeN,    // Byte lane enables, low active
  output logic [31:0]      accWdata,  // Write data
  input  wire logic        accAck,    // Access finished
  input  wire logic [31:0] accRdata   // Read data
);
  eng_state_t state;
  wire launch = acc.start && state == ENG_IDLE &&
                (acc.op == OP_READ || acc.op == OP_WRITE);
  wire finish = state == ENG_BUSY && accAck;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state        <= ENG_IDLE;
      accReq       <= 1'b0;
      accWrite     <= 1'b0;
      accAddr      <= `LAST_ADDR_RESET;
      accBeN       <= `LAST_BE_RESET;
      accWdata     <= 32'h00000000;
      acc.done     <= `DONE_RESET;
      acc.lastOp   <= OP_STATUS;
      acc.lastBeN  <= `LAST_BE_RESET;
      acc.lastAddr <= `LAST_ADDR_RESET;
      acc.rdata    <= 32'h00000000;
    end else if (launch) begin
      state        <= ENG_BUSY;
      accReq       <= 1'b1;
      accWrite     <= acc.op == OP_WRITE;
      accAddr      <= acc.addr;
      accBeN       <= acc.beN;
      accWdata     <= acc.wdata;
      acc.done     <= 1'b0;
      acc.lastOp   <= acc.op;
      acc.lastBeN  <= acc.beN;
      acc.lastAddr <= acc.addr;
    end else if (finish) begin
      state    <= ENG_IDLE;
      accReq   <= 1'b0;
      acc.done <= 1'b1;
      if (!accWrite) begin
        acc.rdata <= accRdata;
      end
    end
  end

  sequence s_launch;
    acc.start && state == ENG_IDLE && acc.op == OP_READ;
  endsequence
  sequence s_issue;
    accReq && !accWrite && !acc.done;
  endsequence
  property p_read_issue;
    @(posedge mclk) disable iff (reset) s_launch |=> s_issue;
  endproperty
  a_read_issue: assert property (p_read_issue) else $error("read not issued");
  property p_pending;
    @(posedge mclk) disable iff (reset) state == ENG_BUSY |-> !acc.done;
  endproperty
  a_pending: assert property (p_pending) else $error("done while busy");
  property p_complete;
    @(posedge mclk) disable iff (reset)
      finish && !accWrite |=> acc.done && acc.rdata == $past(accRdata) && !accReq;
  endproperty
  a_complete: assert property (p_complete) else $error("read data not latched");
endmodule

// File: rtl/spi_cmd_port.sv
// Serial command port: frames SPI commands into 32-bit accesses
`include "spi_cmd_params.svh"
// Function
// - Opcode 10b decodes as 32-bit read
// - Echo previous opcode during opcode bits
// - Byte enables, lane 3 first, active low
// - Echo previous byte enables; status frames send zeros in bits 4-7
// - Address A24..A1 in bits 9-32
// - Echo previous address during address
// - Read status bit at position 40
// - Read data D31 first, bits 41-72
// - Pending read: 32 ignored bits, then poll
// - Read frame is 72 clocks
// - Status command starts no access
// - Opcode 00b decodes as status poll
// - Status frame: done flag at position 8
// - Status after read returns data 9-40
// - Status after write: 32 ignored bits
// - Status frame is 40 clocks
// - Opcode 01b write, data 33-64, status 72
// - Phase and polarity inputs set edges
// - Serial mode latched at reset release
module spi_cmd_port
  import spi_cmd_pkg::*;
(
  input  wire logic        mclk,                    // 10 MHz system clock
  input  wire logic        reset,                   // Synchronous, active high
  input  wire logic        spiClk,                  // Serial clock pin
  input  wire logic        spiMosi,                 // Serial data in
  input  wire logic        spiSelN,                 // Slave select, low active
  input  wire logic        serial_clock_invert_cfg, // Clock polarity pin
  input  wire logic        serial_clock_phase_cfg,  // Clock phase pin
  input  wire logic        interfaceSelN,           // Low at reset: serial mode
  output logic             spiMiso,                 // Serial data out
  output logic             spiMisoOe,               // Drive enable for spiMiso
  output logic             spiModeOn,               // Serial mode latched
  output logic             accReq,                  // Access request level
  output logic             accWrite,                // Access is a write
  output logic [23:0]      accAddr,                 // Word address
  output logic [3:0]       accBeN,                  // Byte lane enables
  output logic [31:0]      accWdata,                // Write data
  input  wire logic        accAck,                  // Access finished
  input  wire logic [31:0] accRdata                 // Read data
);
  access_if acc ();

  // Pin synchronisers, two stages, left running in reset so the mode pin is settled at release
  logic [5:0] pinMeta;
  logic [5:0] pinSync;
  wire  [5:0] pinRaw = {interfaceSelN, serial_clock_phase_cfg,
                        serial_clock_invert_cfg, spiSelN, spiMosi, spiClk};
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_sync
      always_ff @(posedge mclk) begin
        pinMeta[g] <= pinRaw[g];
        pinSync[g] <= pinMeta[g];
      end
    end
  endgenerate

  wire clkS   = pinSync[0];
  wire mosiS  = pinSync[1];
  wire selNS  = pinSync[2];
  wire invS   = pinSync[3];
  wire phaseS = pinSync[4];
  wire ifSelS = pinSync[5];

  // Mode capture at the first cycle after reset release
  logic released;
  always_ff @(posedge mclk) begin
    if (reset) begin
      released  <= 1'b0;
      spiModeOn <= 1'b0;
    end else if (!released) begin
      released  <= 1'b1;
      spiModeOn <= !ifSelS;
    end
  end

  // Edge finding on the effective clock
  logic effPrev;
  logic selPrev;
  wire  effClk    = clkS ^ invS;
  wire  selActive = spiModeOn && !selNS;
  wire  selFall   = selActive && !selPrev;
  wire  leadEdge  = selActive && effClk && !effPrev;
  wire  trailEdge = selActive && !effClk && effPrev;
  wire  sampleEv  = phaseS ? trailEdge : leadEdge;
  wire  shiftEv   = phaseS ? leadEdge : trailEdge;

  // Frame position counters
  logic [6:0]  inPos;
  logic [6:0]  outPos;
  logic [63:0] inShift;
  opcode_t     curOp;
  wire  [63:0] next_inShift = {inShift[62:0], mosiS};
  wire  [6:0]  next_inPos   = inPos + 7'd1;
  wire  [6:0]  next_outPos  = outPos + 7'd1;
  wire         inRoom       = inPos < `FRAME_RW_LEN;
  wire         outRoom      = outPos < `FRAME_RW_LEN;
  wire         doSample     = sampleEv && inRoom;
  wire         doShift      = shiftEv && outRoom && !selFall;
  wire         atOpc        = doSample && next_inPos == `POS_OPC_HI + 7'd1;
  wire         atAddr       = doSample && next_inPos == `POS_ADDR_LAST;
  wire         atData       = doSample && next_inPos == `POS_DATA_LAST;

  // Launch decode
  wire launchRd = atAddr && curOp == OP_READ;
  wire launchWr = atData && curOp == OP_WRITE;

  // Response words, bit 1 of the frame at the top
  wire [31:0] stData = acc.lastOp == OP_READ ? acc.rdata : 32'h00000000;
  wire [71:0] rdVec  = {1'b0, acc.lastOp, acc.lastBeN, 1'b0, acc.lastAddr,
                        7'h00, acc.done, acc.rdata};
  wire [71:0] wrVec  = {1'b0, acc.lastOp, acc.lastBeN, 1'b0, acc.lastAddr,
                        32'h00000000, 7'h00, acc.done};
  wire [71:0] stVec  = {1'b0, acc.lastOp, 4'h0, acc.done, stData,
                        32'h00000000};
  wire [71:0] nopVec = {1'b0, acc.lastOp, acc.lastBeN, 65'h0};
  wire [71:0] respVec = curOp == OP_READ   ? rdVec :
                        curOp == OP_WRITE  ? wrVec :
                        curOp == OP_STATUS ? stVec : nopVec;
  wire [6:0]  shiftIdx = `FRAME_RW_LEN - next_outPos;
  wire [6:0]  firstIdx = `FRAME_RW_LEN - 7'd1;
  wire        shiftBit = respVec[shiftIdx];
  wire        firstBit = respVec[firstIdx];

  always_ff @(posedge mclk) begin
    if (reset) begin
      effPrev <= 1'b0;
      selPrev <= 1'b0;
    end else begin
      effPrev <= effClk;
      selPrev <= selActive;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !selActive || selFall) begin
      inPos   <= 7'd0;
      inShift <= 64'h0;
    end else if (doSample) begin
      inPos   <= next_inPos;
      inShift <= next_inShift;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      curOp <= OP_NOP;
    end else if (atOpc) begin
      curOp <= opcode_t'(next_inShift[1:0]);
    end
  end

  // Serial output; phase 0 presents bit 1 at select fall
  always_ff @(posedge mclk) begin
    if (reset || !selActive) begin
      outPos    <= 7'd0;
      spiMiso   <= 1'b0;
      spiMisoOe <= 1'b0;
    end else if (selFall) begin
      outPos    <= phaseS ? 7'd0 : 7'd1;
      spiMiso   <= phaseS ? 1'b0 : firstBit;
      spiMisoOe <= 1'b1;
    end else if (doShift) begin
      outPos    <= next_outPos;
      spiMiso   <= shiftBit;
    end
  end

  // Request capture towards the engine
  always_ff @(posedge mclk) begin
    if (reset) begin
      acc.start <= 1'b0;
      acc.op    <= OP_STATUS;
      acc.beN   <= `LAST_BE_RESET;
      acc.addr  <= `LAST_ADDR_RESET;
      acc.wdata <= 32'h00000000;
    end else begin
      acc.start <= launchRd || launchWr;
      acc.op    <= curOp;
      if (atAddr) begin
        acc.beN  <= next_inShift[28:25];
        acc.addr <= next_inShift[23:0];
      end
      if (atData) begin
        acc.wdata <= next_inShift[31:0];
      end
    end
  end

  access_engine u_engine (
    .mclk     (mclk),
    .reset    (reset),
    .acc      (acc),
    .accReq   (accReq),
    .accWrite (accWrite),
    .accAddr  (accAddr),
    .accBeN   (accBeN),
    .accWdata (accWdata),
    .accAck   (accAck),
    .accRdata (accRdata)
  );

  // Checks
  sequence s_opc_done;
    atOpc && next_inShift[1:0] == 2'h2;
  endsequence
  sequence s_read_addr;
    atAddr && curOp == OP_READ;
  endsequence
  property p_read_decode;
    @(posedge mclk) disable iff (reset) s_opc_done |=> curOp == OP_READ;
  endproperty
  a_read_decode: assert property (p_read_decode) else $error("read opcode lost");
  property p_read_start;
    @(posedge mclk) disable iff (reset)
      s_read_addr |=> acc.start && acc.addr == $past(next_inShift[23:0]);
  endproperty
  a_read_start: assert property (p_read_start) else $error("read not launched");
  property p_no_access;
    @(posedge mclk) disable iff (reset)
      (curOp == OP_STATUS || curOp == OP_NOP) && !atOpc |=> !acc.start;
  endproperty
  a_no_access: assert property (p_no_access) else $error("poll started access");
  property p_echo_opc;
    @(posedge mclk) disable iff (reset)
      doShift && outPos == 7'd1 |=> spiMiso == acc.lastOp[1];
  endproperty
  a_echo_opc: assert property (p_echo_opc) else $error("opcode echo wrong");
  property p_rd_status;
    @(posedge mclk) disable iff (reset)
      doShift && outPos == `POS_RD_STATUS - 7'd1 && curOp == OP_READ
      |=> spiMiso == $past(acc.done);
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("read status wrong");
  property p_st_status;
    @(posedge mclk) disable iff (reset)
      doShift && outPos == `POS_ST_STATUS - 7'd1 && curOp == OP_STATUS
      |=> spiMiso == $past(acc.done);
  endproperty
  a_st_status: assert property (p_st_status) else $error("poll status wrong");
  property p_hold_miso;
    @(posedge mclk) disable iff (reset)
      selActive && $past(selActive) && !$past(doShift) && !$past(selFall) |-> $stable(spiMiso);
  endproperty
  a_hold_miso: assert property (p_hold_miso) else $error("output moved off edge");
  property p_mode_hold;
    @(posedge mclk) disable iff (reset) released |=> $stable(spiModeOn);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
  property p_len;
    @(posedge mclk) disable iff (reset) inPos <= `FRAME_RW_LEN && outPos <= `FRAME_RW_LEN;
  endproperty
  a_len: assert property (p_len) else $error("frame count overrun");
  property p_wr_start;
    @(posedge mclk) disable iff (reset)
      atData && curOp == OP_WRITE |=> acc.start && acc.wdata == $past(next_inShift[31:0]);
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("write not launched");
  property p_be_capture;
    @(posedge mclk) disable iff (reset)
      atAddr |=> acc.beN == $past(next_inShift[28:25]);
  endproperty
  a_be_capture: assert property (p_be_capture) else $error("lane enables not captured");
  property p_echo_be;
    @(posedge mclk) disable iff (reset)
      doShift && outPos == 7'd3 && curOp != OP_STATUS |=> spiMiso == acc.lastBeN[3];
  endproperty
  a_echo_be: assert property (p_echo_be) else $error("lane echo wrong");
  property p_echo_addr;
    @(posedge mclk) disable iff (reset)
      doShift && outPos == 7'd8 && (curOp == OP_READ || curOp == OP_WRITE) |=> spiMiso == acc.lastAddr[23];
  endproperty
  a_echo_addr: assert property (p_echo_addr) else $error("address echo wrong");
  property p_rd_data;
    @(posedge mclk) disable iff (reset)
      doShift && outPos == 7'd40 && curOp == OP_READ && acc.done |=> spiMiso == $past(acc.rdata[31]);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data first bit wrong");
  property p_st_data;
    @(posedge mclk) disable iff (reset)
      doShift && outPos == 7'd8 && curOp == OP_STATUS && acc.done && acc.lastOp == OP_READ
      |=> spiMiso == $past(acc.rdata[31]);
  endproperty
  a_st_data: assert property (p_st_data) else $error("poll data first bit wrong");
  property p_oe_on;
    @(posedge mclk) disable iff (reset)
      selFall |=> spiMisoOe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not driven in frame");
  property p_oe_off;
    @(posedge mclk) disable iff (reset)
      !selActive |=> !spiMisoOe && !spiMiso;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven outside frame");
  property p_no_mode;
    @(posedge mclk) disable iff (reset)
      !spiModeOn |-> !spiMisoOe && !acc.start;
  endproperty
  a_no_mode: assert property (p_no_mode) else $error("port active outside serial mode");
endmodule

// File: sim/spi_master_model.sv
// Serial master model sending command frames in either clock polarity and phase
module spi_master_model (
  input  wire logic mclk,    // Bench clock, paces the serial clock
  input  wire logic clkIdle,   // Idle level of the serial clock
  input  wire logic shiftLead, // 1: lead edge shifts, trail edge samples
  output logic      spiClk,  // Serial clock, still outside frames
  output logic      spiMosi, // Serial data to the port
  output logic      spiSelN, // Slave select, low active
  input  wire logic spiMiso  // Serial data from the port
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spiClk = 1'b0;
    spiMosi = 1'b0;
    spiSelN = 1'b1;
  end
  // Bit 1 sits at tx[71]; each answer bit lands at the same place in rx
  task automatic xfer(input logic [71:0] tx, input int n, output logic [71:0] rx);
    rx = '0;
    @(negedge mclk);
    spiClk = clkIdle;
    repeat (4) @(negedge mclk);
    spiSelN = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (shiftLead) begin
        repeat (4) @(negedge mclk);
        spiClk = ~clkIdle;
        spiMosi = tx[71 - i];
        repeat (4) @(negedge mclk);
        spiClk = clkIdle;
        rx[71 - i] = spiMiso;
      end else begin
        spiMosi = tx[71 - i];
        repeat (4) @(negedge mclk);
        spiClk = ~clkIdle;
        rx[71 - i] = spiMiso;
        repeat (4) @(negedge mclk);
        spiClk = clkIdle;
      end
    end
    repeat (4) @(negedge mclk);
    spiSelN = 1'b1;
    spiMosi = ~spiMosi;
    repeat (16) @(negedge mclk);
  endtask
endmodule

// File: sim/spi_cmd_port_tb.sv
// Bench for the serial command port: frames, echoes and status polls
module spi_cmd_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        spiClk, spiMosi, spiSelN, spiMiso, spiMisoOe, spiModeOn;
  logic        cfgInvert = 1'b0;
  logic        cfgPhase = 1'b0;
  logic        interfaceSelN = 1'b0;
  logic        accReq, accWrite, accAck;
  logic [23:0] accAddr;
  logic [3:0]  accBeN;
  logic [31:0] accWdata;
  logic [31:0] accRdata = 32'h0;
  logic [31:0] memData = 32'hc3a5_5a3c;
  logic [60:0] seen;
  logic [71:0] rx;
  int          ackDelay = 2;
  int          waitCnt = 0;
  int          nAcc = 0;
  int          nMismatch = 0;
  int          testsRun = 0;
  always #50 mclk = ~mclk;
  spi_cmd_port spi_cmd_port_i (.mclk(mclk), .reset(reset), .spiClk(spiClk), .spiMosi(spiMosi),
    .spiSelN(spiSelN), .serial_clock_invert_cfg(cfgInvert), .serial_clock_phase_cfg(cfgPhase),
    .interfaceSelN(interfaceSelN), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .spiModeOn(spiModeOn),
    .accReq(accReq), .accWrite(accWrite), .accAddr(accAddr), .accBeN(accBeN), .accWdata(accWdata),
    .accAck(accAck), .accRdata(accRdata));
  spi_master_model spi_master_model_i (.mclk(mclk), .spiClk(spiClk), .spiMosi(spiMosi),
    .spiSelN(spiSelN), .spiMiso(spiMiso), .clkIdle(cfgInvert), .shiftLead(cfgPhase));
  // Memory side: records each request, answers after ackDelay cycles
  always @(negedge mclk) begin
    accAck <= 1'b0;
    accRdata <= ~memData;
    if (accReq !== 1'b1) begin
      waitCnt <= 0;
    end else begin
      if (waitCnt == 0) begin
        nAcc <= nAcc + 1;
        seen <= {accWrite, accAddr, accBeN, accWdata};
      end
      waitCnt <= waitCnt + 1;
      if (waitCnt >= ackDelay && accAck === 1'b0) begin
        accAck <= 1'b1;
        accRdata <= memData;
      end
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wrapUp();
    $display("Comparisons %0d, mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Polls with status frames until the done flag shows, at most eight times
  task automatic pollDone();
    for (int k = 0; k < 8; k++) begin
      spi_master_model_i.xfer(72'h0, 40, rx);
      if (rx[64] === 1'b1)
        return;
    end
    nMismatch++;
    $display("Error at %0t ns: done flag never seen", $time);
    wrapUp();
  endtask
  task automatic t_reset();
    chk(spiModeOn, 1'b1, "serial mode");
    chk(spiMisoOe, 1'b0, "idle drive");
    chk(accReq, 1'b0, "idle request");
  endtask
  task automatic t_write();
    ackDelay = 2;
    spi_master_model_i.xfer({1'b0, 2'h1, 4'h5, 1'b0, 24'h5a0f1e, 32'h1234abcd, 8'h00}, 72, rx);
    chk(rx[70:69], 2'h0, "opcode echo");
    chk(rx[68:65], 4'hf, "lane echo");
    chk(rx[63:40], 24'h0, "address echo");
    chk(rx[0], 1'b1, "write status");
    chk(nAcc, 1, "write launched");
    chk(seen[60:29], {1'b1, 24'h5a0f1e, 4'h5, 3'h0}, "write request");
    chk(seen[31:0], 32'h1234abcd, "write data");
  endtask
  task automatic t_read_fast();
    spi_master_model_i.xfer({1'b0, 2'h2, 4'hf, 1'b0, 24'hc30081, 40'h0}, 72, rx);
    chk(rx[70:69], 2'h1, "opcode echo");
    chk(rx[68:65], 4'h5, "lane echo");
    chk(rx[63:40], 24'h5a0f1e, "address echo");
    chk(rx[32], 1'b1, "read status");
    chk(rx[31:0], memData, "read data");
    chk(seen[60:32], {1'b0, 24'hc30081, 4'hf}, "read request");
  endtask
  task automatic t_read_slow();
    ackDelay = 500;
    memData = 32'h0f1e_2d3c;
    spi_master_model_i.xfer({1'b0, 2'h2, 4'hf, 1'b0, 24'h00ffee, 40'h0}, 72, rx);
    chk(rx[32], 1'b0, "pending read status");
    spi_master_model_i.xfer(72'h0, 40, rx);
    chk(rx[70:69], 2'h2, "status opcode echo");
    chk(rx[64], 1'b0, "pending poll flag");
    pollDone();
    chk(rx[63:32], memData, "polled read data");
    chk(nAcc, 3, "polls start nothing");
  endtask
  task automatic t_status_write();
    spi_master_model_i.xfer({1'b0, 2'h1, 4'h0, 1'b0, 24'h000001, 32'h8000_0001, 8'h00}, 72, rx);
    chk(rx[0], 1'b0, "pending write status");
    pollDone();
    chk(rx[63:32], 32'h0, "status after write");
    chk(seen[31:0], 32'h8000_0001, "second write data");
  endtask
  task automatic t_nop();
    spi_master_model_i.xfer({1'b0, 2'h3, 4'ha, 1'b0, 24'hffffff, 40'h0}, 72, rx);
    chk(nAcc, 4, "no-op starts nothing");
    spi_master_model_i.xfer(72'h0, 40, rx);
    chk(rx[70:69], 2'h1, "echo kept after no-op");
    chk(rx[64], 1'b1, "done flag");
  endtask
  task automatic t_modes();
    ackDelay = 2;
    memData = 32'h5a5a_0ff0;
    cfgPhase = 1'b1;
    cfgInvert = 1'b1;
    spi_master_model_i.xfer({1'b0, 2'h2, 4'hf, 1'b0, 24'h123456, 40'h0}, 72, rx);
    chk(rx[70:69], 2'h1, "shift-first opcode echo");
    chk(rx[68:65], 4'h0, "shift-first lane echo");
    chk(rx[63:40], 24'h000001, "shift-first address echo");
    chk(rx[32], 1'b1, "shift-first read status");
    chk(rx[31:0], memData, "shift-first read data");
    chk(nAcc, 5, "shift-first read launched");
    chk(seen[60:32], {1'b0, 24'h123456, 4'hf}, "shift-first read request");
    cfgInvert = 1'b0;
    spi_master_model_i.xfer(72'h0, 40, rx);
    chk(rx[70:69], 2'h2, "idle-low status echo");
    chk(rx[64], 1'b1, "idle-low done flag");
    chk(rx[63:32], memData, "idle-low status data");
    cfgPhase = 1'b0;
    cfgInvert = 1'b1;
    spi_master_model_i.xfer(72'h0, 40, rx);
    chk(rx[64], 1'b1, "idle-high done flag");
    chk(rx[63:32], memData, "idle-high status data");
  endtask
  initial begin
    #2000000;
    nMismatch++;
    $display("Error at %0t ns: run timed out", $time);
    wrapUp();
  end
  initial begin
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    repeat (10) @(negedge mclk);
    t_reset();
    t_write();
    t_read_fast();
    t_read_slow();
    t_status_write();
    t_nop();
    t_modes();
    wrapUp();
  end
endmodule
